// >>> design/tim_pwm_pkg.sv
// package: register map, field positions and reset values of the compare/pwm timer
package cmp_pwm_pkg;
   // register byte addresses (8-bit register port)
   localparam logic [3:0] CTRL_ADDR    = 4'h0;
   localparam logic [3:0] CNTH_ADDR    = 4'h1;
   localparam logic [3:0] CNTL_ADDR    = 4'h2;
   localparam logic [3:0] MODH_ADDR    = 4'h3;
   localparam logic [3:0] MODL_ADDR    = 4'h4;
   localparam logic [3:0] C0CTRL_ADDR  = 4'h5;
   localparam logic [3:0] C0H_ADDR     = 4'h6;
   localparam logic [3:0] C0L_ADDR     = 4'h7;
   localparam logic [3:0] C1CTRL_ADDR  = 4'h8;
   localparam logic [3:0] C1H_ADDR     = 4'h9;
   localparam logic [3:0] C1L_ADDR     = 4'hA;
   // counter control fields
   localparam int OVF_FLAG_BIT  = 7;
   localparam int HALT_BIT      = 5;
   localparam int CLEAR_BIT     = 4;
   localparam int PS_MSB        = 2;
   // channel control fields
   localparam int CH_FLAG_BIT   = 7;
   localparam int MODE_B_BIT    = 5;
   localparam int MODE_A_BIT    = 4;
   localparam int EDGE_B_BIT    = 3;
   localparam int EDGE_A_BIT    = 2;
   localparam int OVF_TOG_BIT   = 1;
   localparam int FULL_DUTY_BIT = 0;
   // reset values
   localparam logic [15:0] MOD_RESET  = 16'hFFFF;
   localparam logic [15:0] CHAN_RESET = 16'h0000;
   localparam logic [2:0]  PS_RESET   = 3'h0;
   localparam logic        HALT_RESET = 1'b1;
   localparam logic [7:0]  CCTL_RESET = 8'h00;
   // compare action decoded from the edge/level pair
   typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} action_t;
endpackage : cmp_pwm_pkg

// >>> design/tick_prescaler.sv
// file: prescaler making the one-cycle counting tick from the bus clock
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
   import cmp_pwm_pkg::*;
#(
   parameter int DIV_W = 6
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       clear,
   input  wire logic       run,
   input  wire logic [2:0] psSel,
   output logic            tick
);
   logic [DIV_W-1:0] divCnt_ff;
   logic [DIV_W-1:0] mask;

   // ps 111 has no internal source here; treated as divide by 64
   assign mask = (psSel == 3'h7) ? {DIV_W{1'b1}}
               : DIV_W'((7'h01 << psSel) - 7'h01);
   assign tick = run && !clear && ((divCnt_ff & mask) == '0);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_ff <= '0;
      end else if (clear) begin
         divCnt_ff <= '0;
      end else if (run) begin
         divCnt_ff <= divCnt_ff + DIV_W'(1);
      end
   end
endmodule : tick_prescaler
`default_nettype wire

// >>> design/timer_compare_pwm_output.sv
// file: 16-bit two-channel output compare and pwm timer core
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - unbuffered compare uses the live channel value; writes take effect at once
// - value rewritten below counter before old match gives no compare that period
// - compare event ends the pulse; overflow event ends the period
// - link select bit pairs channels into one buffered output on channel 0 pin
// - channel 0 controls first; channel 1 takes over at overflow after write
// - at each overflow the most recently written value pair becomes active
// - linked: channel 0 control governs, channel 1 control ignored, pin 1 released
// - toggle-on-overflow toggles the pin when counter reaches modulo
// - pulse width is overflow to compare; compare clears or sets the pin
// - period is modulo plus one prescaled ticks
// - pulse width equals channel value in ticks
// - overflow flag sets when counter reaches modulo
// - counter-clear resets counter and prescaler; self-clears, reads zero
// - overflow toggle off means no overflow toggle, giving 0% duty
// - full-duty bit with overflow toggle holds 100% duty
module timer_compare_pwm_output
   import cmp_pwm_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic [7:0]      regRdata,
   output logic            chan0Pin,
   output logic            chan0PinOe,
   output logic            chan1Pin,
   output logic            chan1PinOe,
   output logic            overflowEvent,
   output logic            compare0Event,
   output logic            compare1Event
);
   // ******************************************************************
   // state
   // ******************************************************************
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] period_ff;
   logic [CNT_W-1:0] value0_ff;
   logic [CNT_W-1:0] value1_ff;
   logic [7:0]       hiLatch_ff;
   logic             halt_ff;
   logic [2:0]       psSel_ff;
   logic             ovfFlag_ff;
   logic             ovfArmed_ff;
   logic [7:0]       c0Ctrl_ff;
   logic [7:0]       c1Ctrl_ff;
   logic [1:0]       chFlag_ff;
   logic [1:0]       chArmed_ff;
   logic             activeSel_ff;
   logic             lastWritten_ff;
   logic             pin0_ff;
   logic             pin1_ff;
   logic [7:0]       rdata_ff;

   logic             tick;
   logic             clearReq;
   logic             wrap;
   logic             linked;
   logic [CNT_W-1:0] cmp0Val;
   logic             match0;
   logic             match1;
   logic [CNT_W-1:0] nxt_count;

   function automatic action_t edge_action(input logic [7:0] ctl);
      case (ctl[EDGE_B_BIT:EDGE_A_BIT])
         2'b01:   edge_action = ACT_TOGGLE;
         2'b10:   edge_action = ACT_CLEAR;
         2'b11:   edge_action = ACT_SET;
         default: edge_action = ACT_NONE;
      endcase
   endfunction : edge_action

   // ordinary pin update: overflow toggle, then compare action
   function automatic logic pin_next(input logic cur, input logic [7:0] ctl,
                                     input logic ovf, input logic cmp);
      logic v;
      v = cur;
      if (ovf && ctl[OVF_TOG_BIT]) begin
         v = ~v;
      end
      if (cmp) begin
         case (edge_action(ctl))
            ACT_TOGGLE: v = ~v;
            ACT_CLEAR:  v = 1'b0;
            ACT_SET:    v = 1'b1;
            default:    v = v;
         endcase
      end
      // full duty holds the pulse level across the whole period
      if (ctl[FULL_DUTY_BIT] && ctl[OVF_TOG_BIT]) begin
         v = (edge_action(ctl) == ACT_CLEAR);
      end
      pin_next = v;
   endfunction : pin_next

   function automatic logic chan_used(input logic [7:0] ctl);
      chan_used = ctl[MODE_B_BIT] | ctl[MODE_A_BIT]
                | (ctl[EDGE_B_BIT:EDGE_A_BIT] != 2'b00);
   endfunction : chan_used

   // ******************************************************************
   // prescaler and counter
   // ******************************************************************
   // halt and clear together park the counter at zero
   assign clearReq = regWr && (regAddr == CTRL_ADDR) && regWdata[CLEAR_BIT];

   tick_prescaler #(
      .DIV_W (6)
   ) u_presc (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clear (clearReq),
      .run   (!halt_ff),
      .psSel (psSel_ff),
      .tick  (tick)
   );

   assign wrap = tick && (count_ff == period_ff);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= '0;
      end else if (clearReq) begin
         count_ff <= '0;
      end else if (wrap) begin
         count_ff <= '0;
      end else if (tick) begin
         count_ff <= count_ff + CNT_W'(1);
      end
   end

   // ******************************************************************
   // compare logic
   // ******************************************************************
   assign linked  = c0Ctrl_ff[MODE_B_BIT];
   assign cmp0Val = (linked && activeSel_ff) ? value1_ff : value0_ff;
   // compares look at the count about to be reached, so the pin moves as
   // the counter lands on the value and the pulse lasts exactly value ticks
   assign nxt_count = wrap ? '0 : count_ff + CNT_W'(1);
   // live register compare: a value already passed does not match again until the counter wraps
   // limitation: a value of zero meets the wrap tick and gives 0% duty
   assign match0    = tick && (nxt_count == cmp0Val);
   assign match1    = tick && !linked && (nxt_count == value1_ff);

   assign overflowEvent = wrap;
   assign compare0Event = match0;
   assign compare1Event = match1;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin0_ff <= 1'b0;
      end else begin
         pin0_ff <= pin_next(pin0_ff, c0Ctrl_ff, wrap, match0);
      end
   end

   // pin 1 freezes while linked; the port logic may reuse the pin
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin1_ff <= 1'b0;
      end else if (!linked) begin
         pin1_ff <= pin_next(pin1_ff, c1Ctrl_ff, wrap, match1);
      end
   end

   assign chan0Pin   = pin0_ff;
   assign chan0PinOe = chan_used(c0Ctrl_ff);
   assign chan1Pin   = pin1_ff;
   assign chan1PinOe = !linked && chan_used(c1Ctrl_ff);

   // ******************************************************************
   // buffered pair selection
   // ******************************************************************
   // a channel 1 write made before linking still counts as the latest
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lastWritten_ff <= 1'b0;
      end else if (regWr && (regAddr == C1L_ADDR)) begin
         lastWritten_ff <= 1'b1;
      end else if (regWr && (regAddr == C0L_ADDR)) begin
         lastWritten_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         activeSel_ff <= 1'b0;
      end else if (!linked) begin
         activeSel_ff <= 1'b0;
      end else if (wrap) begin
         activeSel_ff <= lastWritten_ff;
      end
   end

   // ******************************************************************
   // register writes
   // ******************************************************************
   // high byte is held until the low byte lands, so a value changes whole
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hiLatch_ff <= 8'h00;
      end else if (regWr && (regAddr == MODH_ADDR || regAddr == C0H_ADDR
                             || regAddr == C1H_ADDR)) begin
         hiLatch_ff <= regWdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         period_ff <= MOD_RESET;
      end else if (regWr && regAddr == MODL_ADDR) begin
         period_ff <= CNT_W'({hiLatch_ff, regWdata});
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         value0_ff <= CHAN_RESET;
         value1_ff <= CHAN_RESET;
      end else if (regWr && regAddr == C0L_ADDR) begin
         value0_ff <= CNT_W'({hiLatch_ff, regWdata});
      end else if (regWr && regAddr == C1L_ADDR) begin
         value1_ff <= CNT_W'({hiLatch_ff, regWdata});
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         halt_ff  <= HALT_RESET;
         psSel_ff <= PS_RESET;
      end else if (regWr && regAddr == CTRL_ADDR) begin
         halt_ff  <= regWdata[HALT_BIT];
         psSel_ff <= regWdata[PS_MSB:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         c0Ctrl_ff <= CCTL_RESET;
         c1Ctrl_ff <= CCTL_RESET;
      end else if (regWr && regAddr == C0CTRL_ADDR) begin
         c0Ctrl_ff <= {1'b0, regWdata[6:0]};
      end else if (regWr && regAddr == C1CTRL_ADDR) begin
         // channel 1 cannot link; its mode-b bit stays zero
         c1Ctrl_ff <= {2'b00, regWdata[5:0] & 6'h1F};
      end
   end

   // ******************************************************************
   // flags: read while set arms, a later zero write clears; set wins
   // ******************************************************************
   // the arm step keeps a stale read from clearing a fresh flag
   // a zero write with no read before it leaves the flag alone
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovfFlag_ff  <= 1'b0;
         ovfArmed_ff <= 1'b0;
      end else if (wrap) begin
         ovfFlag_ff  <= 1'b1;
         ovfArmed_ff <= 1'b0;
      end else if (regRd && regAddr == CTRL_ADDR && ovfFlag_ff) begin
         ovfArmed_ff <= 1'b1;
      end else if (regWr && regAddr == CTRL_ADDR
                   && !regWdata[OVF_FLAG_BIT] && ovfArmed_ff) begin
         ovfFlag_ff  <= 1'b0;
         ovfArmed_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chFlag_ff  <= 2'b00;
         chArmed_ff <= 2'b00;
      end else begin
         if (match0) begin
            chFlag_ff[0]  <= 1'b1;
            chArmed_ff[0] <= 1'b0;
         end else if (regRd && regAddr == C0CTRL_ADDR && chFlag_ff[0]) begin
            chArmed_ff[0] <= 1'b1;
         end else if (regWr && regAddr == C0CTRL_ADDR
                      && !regWdata[CH_FLAG_BIT] && chArmed_ff[0]) begin
            chFlag_ff[0]  <= 1'b0;
            chArmed_ff[0] <= 1'b0;
         end
         if (match1) begin
            chFlag_ff[1]  <= 1'b1;
            chArmed_ff[1] <= 1'b0;
         end else if (regRd && regAddr == C1CTRL_ADDR && chFlag_ff[1]) begin
            chArmed_ff[1] <= 1'b1;
         end else if (regWr && regAddr == C1CTRL_ADDR
                      && !regWdata[CH_FLAG_BIT] && chArmed_ff[1]) begin
            chFlag_ff[1]  <= 1'b0;
            chArmed_ff[1] <= 1'b0;
         end
      end
   end

   // ******************************************************************
   // read port
   // ******************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            // clear bit always reads zero
            CTRL_ADDR:   rdata_ff <= {ovfFlag_ff, 1'b0, halt_ff, 2'b00,
                                      psSel_ff};
            CNTH_ADDR:   rdata_ff <= count_ff[15:8];
            CNTL_ADDR:   rdata_ff <= count_ff[7:0];
            MODH_ADDR:   rdata_ff <= period_ff[15:8];
            MODL_ADDR:   rdata_ff <= period_ff[7:0];
            C0CTRL_ADDR: rdata_ff <= {chFlag_ff[0], c0Ctrl_ff[6:0]};
            C0H_ADDR:    rdata_ff <= value0_ff[15:8];
            C0L_ADDR:    rdata_ff <= value0_ff[7:0];
            C1CTRL_ADDR: rdata_ff <= {chFlag_ff[1], c1Ctrl_ff[6:0]};
            C1H_ADDR:    rdata_ff <= value1_ff[15:8];
            C1L_ADDR:    rdata_ff <= value1_ff[7:0];
            default:     rdata_ff <= 8'h00;
         endcase
      end
   end

   // counter bytes read live; no high-byte snapshot between the reads
   assign regRdata = rdata_ff;
endmodule : timer_compare_pwm_output
`default_nettype wire

// >>> bench/tim_pwm_checker_assertions.sv
// checker: port-level assertions for the compare/pwm timer
`timescale 1ns/1ps
`default_nettype none
module cmp_pwm_checker
   import cmp_pwm_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdata,
   input wire logic       chan0Pin,
   input wire logic       chan0PinOe,
   input wire logic       chan1Pin,
   input wire logic       chan1PinOe,
   input wire logic       overflowEvent,
   input wire logic       compare0Event,
   input wire logic       compare1Event
);
   // ************************************
   // channel 0 control shadow and checks
   // ************************************
   logic [7:0] c0Ctl_ff;
   logic       tov;
   logic       fd;
   logic [1:0] edgeSel;
   assign tov     = c0Ctl_ff[OVF_TOG_BIT];
   assign fd      = c0Ctl_ff[FULL_DUTY_BIT];
   assign edgeSel = c0Ctl_ff[EDGE_B_BIT:EDGE_A_BIT];
   // shadow follows writes only; same one-cycle lag as the design's copy
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         c0Ctl_ff <= 8'h00;
      else if (regWr && regAddr == C0CTRL_ADDR)
         c0Ctl_ff <= regWdata;
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence ovfTog;
      overflowEvent && !compare0Event && tov && !fd && edgeSel[1];
   endsequence
   sequence cmpHit;
      compare0Event && !overflowEvent && !fd && edgeSel[1];
   endsequence
   ovf_toggle_a: assert property (ovfTog |=> $changed(chan0Pin))
      else $error("pin did not toggle on overflow");
   cmp_clear_a: assert property ((cmpHit ##0 !edgeSel[0]) |=> !chan0Pin)
      else $error("compare did not clear the pin");
   cmp_set_a: assert property ((cmpHit ##0 edgeSel[0]) |=> chan0Pin)
      else $error("compare did not set the pin");
   full_duty_a: assert property (fd && tov && edgeSel == 2'b10 |=> chan0Pin)
      else $error("full duty output dropped low");
   zero_duty_a: assert property
      (!tov && !fd && edgeSel == 2'b10 |=> !$rose(chan0Pin))
      else $error("pin rose with overflow toggle off");
   link_oe_a: assert property (c0Ctl_ff[MODE_B_BIT] |-> !chan1PinOe)
      else $error("channel 1 pin driven while linked");
   link_cmp1_a: assert property (c0Ctl_ff[MODE_B_BIT] |-> !compare1Event)
      else $error("channel 1 compare while linked");
   clear_rd_a: assert property
      ($past(regRd && regAddr == CTRL_ADDR) |-> !regRdata[CLEAR_BIT])
      else $error("counter clear bit read back as one");
endmodule : cmp_pwm_checker
bind timer_compare_pwm_output cmp_pwm_checker cmp_pwm_checker_i (
   .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .chan0Pin(chan0Pin),
   .chan0PinOe(chan0PinOe), .chan1Pin(chan1Pin), .chan1PinOe(chan1PinOe),
   .overflowEvent(overflowEvent), .compare0Event(compare0Event),
   .compare1Event(compare1Event));
`default_nettype wire

// >>> bench/pin_load.sv
// partner: external load on a channel pin, with a high-time counter
`timescale 1ns/1ps
`default_nettype none
module pin_load (
   input wire logic    mclk,
   input wire logic    pin,
   input wire logic    oe,
   input wire logic    clr,
   output logic        pad,
   output logic [15:0] highCnt
);
   // ************************
   // pad level and high time
   // ************************
   // pull-up, so a released pin always reads high, whatever its last driven level
   assign pad = oe ? pin : 1'b1;
   // clear still counts this cycle, so windows cover whole periods
   always_ff @(posedge mclk) begin
      if (clr)
         highCnt <= 16'(pad);
      else
         highCnt <= highCnt + 16'(pad);
   end
endmodule : pin_load
`default_nettype wire

// >>> bench/timer_compare_pwm_output_tb.sv
// testbench: random and corner-case pwm, compare and linked-mode runs
`timescale 1ns/1ps
`default_nettype none
module timer_compare_pwm_output_tb;
   import cmp_pwm_pkg::*;
   // ************************
   // signals and instances
   // ************************
   logic        mclk, rst_n, regWr, regRd, clr, pad0, pad1;
   logic        chan0Pin, chan0PinOe, chan1Pin, chan1PinOe;
   logic        overflowEvent, compare0Event, compare1Event;
   logic [3:0]  regAddr;
   logic [7:0]  regWdata, regRdata, d;
   logic [15:0] high0, high1, md, vl;
   logic [2:0]  ps;
   int          miscompares, samples_checked, seed, n;
   timer_compare_pwm_output timer_compare_pwm_output_i (
      .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .chan0Pin(chan0Pin), .chan0PinOe(chan0PinOe), .chan1Pin(chan1Pin),
      .chan1PinOe(chan1PinOe), .overflowEvent(overflowEvent),
      .compare0Event(compare0Event), .compare1Event(compare1Event));
   pin_load pin_load_0 (.mclk(mclk), .pin(chan0Pin), .oe(chan0PinOe),
      .clr(clr), .pad(pad0), .highCnt(high0));
   pin_load pin_load_1 (.mclk(mclk), .pin(chan1Pin), .oe(chan1PinOe),
      .clr(clr), .pad(pad1), .highCnt(high1));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ************************
   // tasks
   // ************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // cycles taken by a count of prescaled ticks
   function automatic logic [15:0] ticks(input logic [15:0] t,
                                         input logic [2:0]  p);
      ticks = t << p;
   endfunction : ticks
   task automatic print_verdict;
      $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= v;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask : rd
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      wr(a, v[15:8]);
      wr(a + 4'h1, v[7:0]);
   endtask : wr16
   // halt and clear first, then period, width, channel, start
   task automatic pwmSetup(input logic [7:0] ctl);
      wr(CTRL_ADDR, 8'h30);
      wr16(MODH_ADDR, md);
      wr16(C0H_ADDR, vl);
      wr(C0CTRL_ADDR, ctl);
      wr(CTRL_ADDR, {5'h00, ps});
   endtask : pwmSetup
   // restarts the load's window; returns cycles up to the next overflow
   task automatic waitOvf(output int cnt);
      clr <= 1'b1;
      cnt = 0;
      do begin
         @(posedge mclk);
         clr <= 1'b0;
         cnt++;
      end while (overflowEvent !== 1'b1 && cnt < 3000);
      if (cnt >= 3000) begin
         miscompares++;
         print_verdict;
      end else begin
         #1;
      end
   endtask : waitOvf
   // bounded wait for a channel 0 compare, as a compare handler would
   task automatic waitCmp;
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (compare0Event !== 1'b1 && k < 3000);
      if (k >= 3000) begin
         miscompares++;
         print_verdict;
      end
   endtask : waitCmp
   // ************************
   // main sequence
   // ************************
   initial begin
      seed = 80596;
      miscompares = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      clr = 1'b0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      rd(CTRL_ADDR, d);
      chk(16'(d), 16'h0020);
      rd(4'hF, d);
      chk(16'(d), 16'h0000);
      // first pass is the 50 percent corner, then random
      for (int i = 0; i < 6; i++) begin
         md = (i == 0) ? 16'h00FF : 16'(4 + ($random(seed) & 15));
         vl = (i == 0) ? 16'h0080 : 16'(1 + {$random(seed)} % (md - 1));
         ps = (i == 0) ? 3'h0 : 3'($random(seed) & 1);
         pwmSetup(8'h1A);
         waitOvf(n);
         waitOvf(n);
         chk(16'(n), ticks(md + 16'h0001, ps));
         chk(high0, ticks(vl, ps));
         rd(CTRL_ADDR, d);
         chk(16'(d[OVF_FLAG_BIT]), 16'h0001);
      end
      wr(CTRL_ADDR, 8'h30);
      rd(CNTL_ADDR, d);
      chk(16'(d), 16'h0000);
      pwmSetup(8'h1B);
      waitOvf(n);
      waitOvf(n);
      chk(high0, 16'(n));
      wr(C0CTRL_ADDR, 8'h1E);
      waitOvf(n);
      waitOvf(n);
      chk(high0, 16'(n) - ticks(vl, ps));
      wr(C0CTRL_ADDR, 8'h18);
      repeat (3) waitOvf(n);
      chk(high0, 16'h0000);
      // lowered mid-period after the counter passed it: no compare
      md = 16'h000F;
      vl = 16'h000C;
      ps = 3'h0;
      pwmSetup(8'h1A);
      waitOvf(n);
      fork
         waitOvf(n);
         begin
            repeat (5) @(posedge mclk);
            wr16(C0H_ADDR, 16'h0003);
         end
      join
      chk(high0, 16'h0010);
      waitOvf(n);
      waitOvf(n);
      chk(high0, 16'h0003);
      // raise in the overflow handler, lower in the compare handler
      wr16(C0H_ADDR, 16'h000A);
      waitOvf(n);
      waitOvf(n);
      chk(high0, 16'h000A);
      waitCmp;
      wr16(C0H_ADDR, 16'h0006);
      waitOvf(n);
      waitOvf(n);
      chk(high0, 16'h0006);
      // channel 1 on its own, before the link takes it over
      wr16(C1H_ADDR, 16'h0005);
      wr(C1CTRL_ADDR, 8'h1A);
      waitOvf(n);
      waitOvf(n);
      chk(high1, 16'h0005);
      // linked pair; channel 1 drives low until the link releases it
      wr(C1CTRL_ADDR, 8'h18);
      wr16(C0H_ADDR, 16'h0004);
      wr(C0CTRL_ADDR, 8'h2A);
      waitOvf(n);
      waitOvf(n);
      chk(high0, 16'h0004);
      chk(16'(pad1), 16'h0001);
      wr16(C1H_ADDR, 16'h0009);
      waitOvf(n);
      waitOvf(n);
      chk(high0, 16'h0009);
      wr16(C0H_ADDR, 16'h0006);
      waitOvf(n);
      waitOvf(n);
      chk(high0, 16'h0006);
      // mid-run reset brings back the halted, released reset state
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      chk(16'({chan0Pin, chan0PinOe, chan1PinOe}), 16'h0000);
      rd(CTRL_ADDR, d);
      chk(16'(d), 16'h0020);
      print_verdict;
   end
endmodule : timer_compare_pwm_output_tb
`default_nettype wire
